// >>> eeprom_host_consts.svh
// Purpose: Timing counts and widths for the parallel memory write and poll controller.
// Assumes: 125 MHz system clock, 8 ns period.
// Notes:   Times are kept in their own unit and converted to clock cycles here.
`ifndef EEPROM_HOST_CONSTS_SVH
`define EEPROM_HOST_CONSTS_SVH
`define CLK_NS            8
`define ADDR_W            13
`define DATA_W            8
`define PAGE_BYTES        32
`define OFFSET_W          5
`define TOP_BIT           7
`define STROBE_NS         150
`define STROBE_CYC        ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define SETUP_NS          70
`define SETUP_CYC         ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_NS           100
`define HOLD_CYC          ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define OE_ACCESS_NS      250
`define OE_ACCESS_CYC     ((`OE_ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define WINDOW_MIN_US     10
`define WINDOW_MIN_CYC    ((`WINDOW_MIN_US * 1000) / `CLK_NS)
`define WINDOW_MAX_US     100
`define WINDOW_MAX_CYC    ((`WINDOW_MAX_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define WRITE_MAX_MS      10
`define WRITE_MAX_CYC     ((`WRITE_MAX_MS * 1000000) / `CLK_NS)
`define INIT_MAX_MS       20
`define INIT_MAX_CYC      ((`INIT_MAX_MS * 1000000 + `CLK_NS - 1) / `CLK_NS)
`endif

// >>> eeprom_host_pkg.sv
// Purpose: Types for the parallel memory write and poll controller.
// Assumes: Constants come from the shared header.
// Notes:   Only the state type lives here.
package eeprom_host_pkg;
    typedef enum logic [3:0]
    {
        ST_INIT,
        ST_IDLE,
        ST_WR_LOW,
        ST_WR_HOLD,
        ST_WR_GAP,
        ST_SETTLE,
        ST_POLL_LOW,
        ST_POLL_HIGH,
        ST_RD_LOW,
        ST_RD_HIGH
    } state_e;
endpackage : eeprom_host_pkg

// >>> eeprom_host.sv
// Purpose: Host controller that drives a parallel memory through its strobes.
// Assumes: Pins are asynchronous to clk_sys; data inputs pass three flip-flops.
// Notes:   Page loads are spaced inside the byte load window, then polled.
`timescale 1ns/1ns
`include "eeprom_host_consts.svh"
module eeprom_host
    import eeprom_host_pkg::*;
#(
    parameter int INIT_CYC    = `INIT_MAX_CYC,
    parameter int WRITE_CYC   = `WRITE_MAX_CYC,
    parameter int WIN_MAX_CYC = `WINDOW_MAX_CYC
)
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 wr_valid,
    output logic                      wr_ready,
    input  wire logic [`ADDR_W-1:0]   wr_addr,
    input  wire logic [`DATA_W-1:0]   wr_data,
    input  wire logic                 wr_last,
    input  wire logic                 rd_valid,
    output logic                      rd_ready,
    input  wire logic [`ADDR_W-1:0]   rd_addr,
    output logic                      rd_done,
    output logic [`DATA_W-1:0]        rd_data,
    output logic                      prog_busy,
    output logic                      prog_timeout,
    output logic [`ADDR_W-1:0]        mem_addr,
    output logic                      chip_sel_n,
    output logic                      out_en_n,
    output logic                      wr_strobe_n,
    input  wire logic [`DATA_W-1:0]   data_in,
    output logic [`DATA_W-1:0]        data_out,
    output logic                      data_oe
);
    // ==========================================================
    // Pin input synchroniser
    // ==========================================================
    logic [`DATA_W-1:0] sync1;
    logic [`DATA_W-1:0] sync2;
    logic [`DATA_W-1:0] sync3;
    logic [`DATA_W-1:0] next_sync1;
    logic [`DATA_W-1:0] next_sync2;
    logic [`DATA_W-1:0] next_sync3;
    logic [`DATA_W-1:0] pin_data;

    always_comb
    begin
        next_sync1 = data_in;
        next_sync2 = sync1;
        next_sync3 = sync2;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
            sync3 <= 8'h00;
        end
        else
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sync3 <= next_sync3;
        end
    end

    // A bit counts as settled only once the second and third stages agree.
    assign pin_data = sync2 & sync3;
    logic pin_stable;
    assign pin_stable = (sync2 == sync3);

    // ==========================================================
    // Sequencer
    // ==========================================================
    state_e             state;
    state_e             next_state;
    logic [31:0]        cnt;
    logic [31:0]        next_cnt;
    logic [31:0]        wait_cnt;
    logic [31:0]        next_wait_cnt;
    logic [`ADDR_W-1:0] addr;
    logic [`ADDR_W-1:0] next_addr;
    logic [`DATA_W-1:0] wdata;
    logic [`DATA_W-1:0] next_wdata;
    logic [`DATA_W-1:0] rdata;
    logic [`DATA_W-1:0] next_rdata;
    logic               last;
    logic               next_last;
    logic               done;
    logic               next_done;
    logic               tmo;
    logic               next_tmo;
    logic [5:0]         loaded;
    logic [5:0]         next_loaded;
    logic               next_chip_sel_n;
    logic               next_out_en_n;
    logic               next_wr_strobe_n;
    logic               next_data_oe;

    // Gap after a load: long enough to settle, short enough to stay in the window.
    localparam int GAP_CYC = `WINDOW_MIN_CYC / 2;

    always_comb
    begin
        next_state    = state;
        next_cnt      = (cnt == 32'h0) ? 32'h0 : cnt - 32'h1;
        next_wait_cnt = wait_cnt;
        next_addr     = addr;
        next_wdata    = wdata;
        next_rdata    = rdata;
        next_last     = last;
        next_done     = 1'b0;
        next_tmo      = tmo;
        next_loaded   = loaded;
        case (state)
            ST_INIT:
            begin
                if (cnt == 32'h0)
                    next_state = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (wr_valid)
                begin
                    next_addr   = wr_addr;
                    next_wdata  = wr_data;
                    next_last   = wr_last || (loaded == 6'(`PAGE_BYTES - 1));
                    next_cnt    = 32'(`STROBE_CYC);
                    next_tmo    = 1'b0;
                    next_state  = ST_WR_LOW;
                end
                else if (rd_valid)
                begin
                    next_addr  = rd_addr;
                    next_cnt   = 32'(`OE_ACCESS_CYC + 2);
                    next_state = ST_RD_LOW;
                end
            end
            ST_WR_LOW:
            begin
                if (cnt == 32'h0)
                begin
                    next_cnt   = 32'(`HOLD_CYC);
                    next_state = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD:
            begin
                if (cnt == 32'h0)
                begin
                    next_loaded = loaded + 6'h1;
                    if (last)
                    begin
                        next_loaded = 6'h0;
                        next_cnt    = 32'(WIN_MAX_CYC);
                        next_state  = ST_SETTLE;
                    end
                    else
                    begin
                        next_cnt   = 32'(GAP_CYC);
                        next_state = ST_WR_GAP;
                    end
                end
            end
            ST_WR_GAP:
            begin
                // Next byte must be ready before the window closes.
                if (wr_valid)
                begin
                    next_addr  = wr_addr;
                    next_wdata = wr_data;
                    next_last  = wr_last || (loaded == 6'(`PAGE_BYTES - 1));
                    next_cnt   = 32'(`STROBE_CYC);
                    next_state = ST_WR_LOW;
                end
                else if (cnt == 32'h0)
                begin
                    next_loaded = 6'h0;
                    next_cnt    = 32'(WIN_MAX_CYC);
                    next_state  = ST_SETTLE;
                end
            end
            ST_SETTLE:
            begin
                if (cnt == 32'h0)
                begin
                    next_wait_cnt = 32'(WRITE_CYC);
                    next_cnt      = 32'(`OE_ACCESS_CYC + 2);
                    next_state    = ST_POLL_LOW;
                end
            end
            ST_POLL_LOW:
            begin
                next_wait_cnt = (wait_cnt == 32'h0) ? 32'h0 : wait_cnt - 32'h1;
                if (cnt == 32'h0 && pin_stable)
                begin
                    next_cnt   = 32'(`SETUP_CYC);
                    next_state = ST_POLL_HIGH;
                    if (pin_data[`TOP_BIT] == wdata[`TOP_BIT])
                        next_state = ST_IDLE;
                    else if (wait_cnt == 32'h0)
                    begin
                        next_tmo   = 1'b1;
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_POLL_HIGH:
            begin
                next_wait_cnt = (wait_cnt == 32'h0) ? 32'h0 : wait_cnt - 32'h1;
                if (cnt == 32'h0)
                begin
                    next_cnt   = 32'(`OE_ACCESS_CYC + 2);
                    next_state = ST_POLL_LOW;
                end
            end
            ST_RD_LOW:
            begin
                if (cnt == 32'h0 && pin_stable)
                begin
                    next_rdata = pin_data;
                    next_done  = 1'b1;
                    next_cnt   = 32'(`SETUP_CYC);
                    next_state = ST_RD_HIGH;
                end
            end
            ST_RD_HIGH:
            begin
                if (cnt == 32'h0)
                    next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        // Strobes are decoded from the next state and registered, so a multi-bit state change cannot glitch them.
        // Output enable stays high across every write so the memory never drives back.
        next_wr_strobe_n = (next_state != ST_WR_LOW);
        next_chip_sel_n  = !(next_state == ST_WR_LOW || next_state == ST_WR_HOLD
                             || next_state == ST_POLL_LOW || next_state == ST_RD_LOW);
        next_out_en_n    = !(next_state == ST_POLL_LOW || next_state == ST_RD_LOW);
        next_data_oe     = (next_state == ST_WR_LOW || next_state == ST_WR_HOLD);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state    <= ST_INIT;
            cnt      <= 32'(INIT_CYC);
            wait_cnt <= 32'h0;
            addr     <= 13'h0000;
            wdata    <= 8'h00;
            rdata    <= 8'h00;
            last     <= 1'b0;
            done     <= 1'b0;
            tmo      <= 1'b0;
            loaded   <= 6'h00;
            chip_sel_n  <= 1'b1;
            out_en_n    <= 1'b1;
            wr_strobe_n <= 1'b1;
            data_oe     <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            cnt      <= next_cnt;
            wait_cnt <= next_wait_cnt;
            addr     <= next_addr;
            wdata    <= next_wdata;
            rdata    <= next_rdata;
            last     <= next_last;
            done     <= next_done;
            tmo      <= next_tmo;
            loaded   <= next_loaded;
            chip_sel_n  <= next_chip_sel_n;
            out_en_n    <= next_out_en_n;
            wr_strobe_n <= next_wr_strobe_n;
            data_oe     <= next_data_oe;
        end
    end

    // ==========================================================
    // Pin drive
    // ==========================================================
    assign data_out     = wdata;
    assign mem_addr     = addr;
    assign wr_ready     = (state == ST_IDLE) || (state == ST_WR_GAP);
    assign rd_ready     = (state == ST_IDLE) && !wr_valid;
    assign rd_done      = done;
    assign rd_data      = rdata;
    assign prog_busy    = (state == ST_SETTLE) || (state == ST_POLL_LOW) || (state == ST_POLL_HIGH);
    assign prog_timeout = tmo;

    // ==========================================================
    // Checks
    // ==========================================================
    a_write_oe_high: assert property (@(posedge clk_sys) disable iff (rst)
        !wr_strobe_n |-> (out_en_n && !chip_sel_n))
        else $error("write strobe low without select low and output enable high");
    a_strobe_width: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(wr_strobe_n) |-> !wr_strobe_n [*8])
        else $error("write strobe pulse too short");
    a_no_drive_read: assert property (@(posedge clk_sys) disable iff (rst)
        !out_en_n |-> !data_oe)
        else $error("host drives data while memory output enabled");
    a_init_blocks: assert property (@(posedge clk_sys) disable iff (rst)
        (state == ST_INIT) |-> wr_strobe_n)
        else $error("write during power-up inhibit");
    a_last_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (state == ST_WR_HOLD && cnt == 32'h0 && last) |=> (state == ST_SETTLE && cnt == 32'(WIN_MAX_CYC)))
        else $error("page end not followed by full load window");
    a_gap_window: assert property (@(posedge clk_sys) disable iff (rst)
        (state == ST_WR_GAP) |-> (cnt <= 32'(GAP_CYC)))
        else $error("load gap exceeds window");
    a_poll_bound: assert property (@(posedge clk_sys) disable iff (rst)
        (state == ST_POLL_LOW && wait_cnt == 32'h0 && cnt == 32'h0 && pin_stable
         && pin_data[`TOP_BIT] != wdata[`TOP_BIT]) |=> (state == ST_IDLE && tmo))
        else $error("poll timeout not flagged");
    a_data_stable: assert property (@(posedge clk_sys) disable iff (rst)
        (state == ST_WR_LOW) |=> $stable(data_out) || state != ST_WR_LOW)
        else $error("write data changed while strobe low");
endmodule : eeprom_host

// >>> eeprom_dev_model.sv
// Purpose: Behavioural model of the parallel memory on the host pins.
// Assumes: Times in ns; timers are scaled down to keep runs short.
// Notes:   misuse latches a bus clash or a write the host should not make.
`timescale 1ns/1ns
`include "eeprom_host_consts.svh"
module eeprom_dev_model
#(
    parameter int INIT_NS = 250,
    parameter int BLC_NS  = 5500,
    parameter int PROG_NS = 20000
)
(
    input  wire logic [`ADDR_W-1:0] mem_addr,
    input  wire logic               chip_sel_n,
    input  wire logic               out_en_n,
    input  wire logic               wr_strobe_n,
    input  wire logic [`DATA_W-1:0] dq,
    input  wire logic               host_oe,
    input  wire logic               hold_busy,
    output logic      [`DATA_W-1:0] dev_dq,
    output logic                    misuse
);
    // ==========
    // State
    logic [7:0]  mem [0:8191];
    logic [7:0]  pbuf [0:31];
    logic [31:0] pmask     = '0;
    logic [12:0] lat_addr  = '0;
    logic [12:0] last_addr = '0;
    logic [7:0]  last_data = 8'h00;
    logic [7:0]  float_val = 8'hA5;
    logic [7:0]  page      = 8'h00;
    logic        busy      = 1'b0;
    logic        inhib     = 1'b1;
    realtime     t_low     = 0;
    event        go;
    wire         wcond     = !chip_sel_n && !wr_strobe_n && out_en_n;
    wire         rd_en     = !chip_sel_n && !out_en_n && wr_strobe_n;
    wire  [7:0]  rd_val    = (busy && mem_addr == last_addr) ?
                             {~last_data[7], ~float_val[6:0]} : mem[mem_addr];
    // A released bus shows the inverse of its last value, so a stale read cannot pass.
    assign dev_dq = rd_en ? rd_val : float_val;
    initial
    begin
        misuse = 1'b0;
        for (int i = 0; i < 8192; i++)
            mem[i] = 8'hFF;
        #INIT_NS;
        inhib = 1'b0;
    end
    always @(negedge rd_en)
        float_val = ~rd_val;
    always @(rd_en or host_oe)
        if (rd_en && host_oe)
            misuse = 1'b1;
    always @(posedge wcond)
    begin
        // Address and strobes change in one time step; let the address settle before latching.
        #0;
        lat_addr = mem_addr;
        t_low    = $realtime;
        if (inhib || busy)
            misuse = 1'b1;
    end
    always @(negedge wcond)
        if (!inhib && !busy && $realtime - t_low >= 20.0)
        begin
            pbuf[lat_addr[4:0]]  = dq;
            pmask[lat_addr[4:0]] = 1'b1;
            page                 = lat_addr[12:5];
            last_addr            = lat_addr;
            last_data            = dq;
        end
    initial forever
    begin
        @(posedge wr_strobe_n);
        fork : blc
            begin
                #BLC_NS;
                -> go;
            end
            @(negedge wr_strobe_n);
        join_any
        disable blc;
    end
    always @(go)
        if (pmask != 0)
        begin
            busy = 1'b1;
            #PROG_NS;
            wait (!hold_busy);
            for (int i = 0; i < 32; i++)
                if (pmask[i])
                    mem[{page, 5'(i)}] = pbuf[i];
            pmask = '0;
            busy  = 1'b0;
        end
endmodule : eeprom_dev_model

// >>> test_eeprom_host.sv
// Purpose: Self-checking bench for the parallel memory host controller.
// Assumes: Device model on the pins; init, write and settle counts scaled down.
// Notes:   Expected values come from the bench's own tables.
`timescale 1ns/1ns
`include "eeprom_host_consts.svh"
module test_eeprom_host;
    // ==========
    // Signals and instances
    logic               clk_sys   = 1'b0;
    logic               rst       = 1'b1;
    logic               wr_valid  = 1'b0;
    logic               wr_last   = 1'b0;
    logic               rd_valid  = 1'b0;
    logic               hold_busy = 1'b0;
    logic [`ADDR_W-1:0] wr_addr   = '0;
    logic [`ADDR_W-1:0] rd_addr   = '0;
    logic [`DATA_W-1:0] wr_data   = '0;
    logic               wr_ready, rd_ready, rd_done, prog_busy, prog_timeout;
    logic               chip_sel_n, out_en_n, wr_strobe_n, data_oe, misuse;
    logic [`ADDR_W-1:0] mem_addr;
    logic [`DATA_W-1:0] rd_data, data_out, dev_dq, dq;
    int                 bad_count  = 0;
    int                 n_compared = 0;
    assign dq = data_oe ? data_out : dev_dq;
    eeprom_host #(.INIT_CYC(20), .WRITE_CYC(4000), .WIN_MAX_CYC(700)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_last(wr_last), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_done(rd_done), .rd_data(rd_data),
        .prog_busy(prog_busy), .prog_timeout(prog_timeout), .mem_addr(mem_addr),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
        .data_in(dq), .data_out(data_out), .data_oe(data_oe));
    eeprom_dev_model i_mem (
        .mem_addr(mem_addr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .wr_strobe_n(wr_strobe_n), .dq(dq), .host_oe(data_oe), .hold_busy(hold_busy),
        .dev_dq(dev_dq), .misuse(misuse));
    initial forever #4 clk_sys = ~clk_sys;
    // ==========
    // Helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wait_hi(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (s !== v && n < lim)
        begin
            n++;
            @(negedge clk_sys);
        end
        if (s !== v)
        begin
            bad_count++;
            $display("unexpected at %0t: wait gave up", $time);
        end
    endtask : wait_hi
    task automatic wr_byte(input logic [12:0] a, input logic [7:0] d, input logic last);
        @(posedge clk_sys);
        #1;
        wr_valid = 1'b1;
        wr_addr  = a;
        wr_data  = d;
        wr_last  = last;
        wait_hi(wr_ready, 1'b1, 2000);
        @(posedge clk_sys);
        #1;
        wr_valid = 1'b0;
        wr_last  = 1'b0;
    endtask : wr_byte
    task automatic rd_byte(input logic [12:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        rd_valid = 1'b1;
        rd_addr  = a;
        wait_hi(rd_ready, 1'b1, 2000);
        @(posedge clk_sys);
        #1;
        rd_valid = 1'b0;
        wait_hi(rd_done, 1'b1, 200);
        d = rd_data;
    endtask : rd_byte
    task automatic wait_idle();
        wait_hi(prog_busy, 1'b1, 300);
        wait_hi(prog_busy, 1'b0, 8000);
    endtask : wait_idle
    // ==========
    // Scenarios
    task automatic t_power();
        repeat (10) @(posedge clk_sys);
        #1;
        chk(8'({wr_ready, rd_ready, data_oe}), 8'h00, "inhibit ready");
        chk(8'({chip_sel_n, wr_strobe_n}), 8'h03, "idle strobes");
        wait_hi(wr_ready, 1'b1, 40);
        $display("test power done");
    endtask : t_power
    task automatic t_byte();
        logic [7:0] d;
        wr_byte(13'h0155, 8'hC3, 1'b1);
        wait_idle();
        chk(8'(prog_timeout), 8'h00, "byte poll");
        rd_byte(13'h0155, d);
        chk(d, 8'hC3, "byte readback");
        $display("test byte done");
    endtask : t_byte
    task automatic t_page();
        logic [7:0] exp [0:31];
        logic [7:0] d;
        logic [4:0] offs [3] = '{5'h05, 5'h11, 5'h1E};
        for (int i = 0; i < 32; i++)
        begin
            exp[31-i] = 8'(i * 7 + 1);
            wr_byte({8'h12, 5'(31 - i)}, exp[31-i], i == 31);
        end
        wait_idle();
        for (int k = 0; k < 3; k++)
        begin
            exp[offs[k]] = ~exp[offs[k]];
            wr_byte({8'h12, offs[k]}, exp[offs[k]], k == 2);
        end
        wait_idle();
        for (int i = 0; i < 32; i++)
        begin
            rd_byte({8'h12, 5'(i)}, d);
            chk(d, exp[i], "page byte");
        end
        $display("test page done");
    endtask : t_page
    task automatic t_timeout();
        logic [7:0] d;
        hold_busy = 1'b1;
        wr_byte(13'h1FE0, 8'h5A, 1'b1);
        wait_idle();
        chk(8'(prog_timeout), 8'h01, "poll timeout");
        hold_busy = 1'b0;
        wr_byte(13'h1FE1, 8'hA5, 1'b1);
        wait_idle();
        chk(8'(prog_timeout), 8'h00, "timeout cleared");
        rd_byte(13'h1FE0, d);
        chk(d, 8'h5A, "held byte");
        rd_byte(13'h1FE1, d);
        chk(d, 8'hA5, "next byte");
        $display("test timeout done");
    endtask : t_timeout
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_power();
        t_byte();
        t_page();
        t_timeout();
        chk(8'(misuse), 8'h00, "bus use");
        finish_test();
    end
    // The whole run needs about 20000 cycles; the margin covers slow polls.
    initial
    begin
        #(50000 * 8);
        bad_count++;
        finish_test();
    end
endmodule : test_eeprom_host
